// file: core/tusseq_pkg.sv
// Shared constants, field positions and state encoding for the tape status sequencer.
package tusseq_pkg;

  // Word and drive geometry.
  localparam int WORD_W = 30;
  localparam int NUM_DRIVES = 7;
  localparam int LINES_PER_DRIVE = 8;
  localparam int LINE_BUS_W = NUM_DRIVES * LINES_PER_DRIVE;
  localparam int NUM_COND = 4;
  localparam int INSTR_W = 4;

  // Host command word fields.
  localparam int CMD_XFER_OUT_BIT = 4;
  localparam int CMD_XFER_IN_BIT = 5;
  localparam int CMD_LOCKOUT_BIT = 7;
  localparam int CMD_INSTR_LSB = 11;
  localparam int CMD_ADDR_LSB = 15;

  // Status report word fields.
  localparam int ST_FAULT_SUM = 0;
  localparam int ST_NOT_READY = 1;
  localparam int ST_COND_SUM = 2;
  localparam int ST_DRIVE_FAULT = 3;
  localparam int ST_SILENT = 4;
  localparam int ST_PARITY = 5;
  localparam int ST_TIMING = 6;
  localparam int ST_COND_LSB = 11;
  localparam int ST_COND_MSB = 14;
  localparam int ST_READY_LSB = 23;
  localparam int ST_READY_MSB = 29;
  localparam logic [29:0] STATUS_RESET = 30'h0;

  // Line positions inside each drive's group of eight input lines.
  localparam int LN_READY = 0;
  localparam int LN_NOT_READY = 1;
  localparam int LN_FAULT = 2;
  localparam int LN_NO_COND = 3;
  localparam int LN_COND_W = 4;

  // Response window after the probe, in nanoseconds, and its cycle count.
  localparam int RESP_WINDOW_NS = 2000;
  localparam int CLK_MHZ = 200;
  localparam int RESP_CYCLES = (RESP_WINDOW_NS * CLK_MHZ + 999) / 1000;

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PROBE,
    ST_WAIT,
    ST_DECIDE,
    ST_XFER,
    ST_REPORT
  } tusseq_state_e;

endpackage

// file: core/tusseq_tmr_if.sv
// Interface joining the sequencer to its response window timer.
`timescale 1ns/100ps
interface tusseq_tmr_if;
  // Load and run the window for one cycle pulse.
  logic start;
  // Abandon a running window.
  logic stop;
  // One cycle pulse when the window runs out.
  logic expired;
  modport owner (output start, output stop, input expired);
  modport timer (input start, input stop, output expired);
endinterface

// file: core/tusseq_sync.sv
// Two flip-flop synchroniser for a bus of drive pin inputs.
`timescale 1ns/100ps
module tusseq_sync #(
  parameter int WIDTH = 8
) (
  // Clock, reset and enable.
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  // Pins in, synchronised copy out.
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  // The first stage is read only by the second stage.
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } tusseq_sync_s;

  tusseq_sync_s s;
  tusseq_sync_s next_s;

  if (WIDTH < 1) begin : g_width_check
    $error("tusseq_sync needs a positive width.");
  end

  // Shift the pins through both stages.
  always_comb begin
    next_s.meta = i_async;
    next_s.sync = s.meta;
  end

  // Hold state while the enable is low.
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      s <= '0;
    end else if (i_clk_en) begin
      s <= next_s;
    end
  end

  assign o_sync = s.sync;

endmodule

// file: core/tusseq_timer.sv
// Response window timer that bounds how long the sequencer waits for drives.
`timescale 1ns/100ps
module tusseq_timer #(
  parameter int CYCLES = tusseq_pkg::RESP_CYCLES
) (
  // Clock, reset and enable.
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  // Control from the sequencer.
  tusseq_tmr_if.timer tmr
);

  localparam int CNT_W = $clog2(CYCLES + 1);

  typedef struct packed {
    logic running;
    logic [CNT_W-1:0] cnt;
  } tusseq_tmr_s;

  tusseq_tmr_s s;
  tusseq_tmr_s next_s;

  if (CYCLES < 1) begin : g_cycles_check
    $error("tusseq_timer needs at least one cycle.");
  end

  // The window ends on the cycle its last count is reached.
  assign tmr.expired = s.running && (s.cnt == CNT_W'(1));

  // Start reloads, stop and expiry both idle the counter.
  always_comb begin
    next_s = s;
    if (tmr.start) begin
      next_s.running = 1'b1;
      next_s.cnt = CNT_W'(CYCLES);
    end else if (tmr.stop || tmr.expired) begin
      next_s.running = 1'b0;
      next_s.cnt = '0;
    end else if (s.running) begin
      next_s.cnt = s.cnt - CNT_W'(1);
    end
  end

  // Register the counter; frozen while the enable is low.
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      s <= '0;
    end else if (i_clk_en) begin
      s <= next_s;
    end
  end

endmodule

// file: core/tusseq_top.sv
// Control-phase sequencer of the tape controller: probe, query, status word and proceed decision.
`timescale 1ns/100ps
module tusseq_top #(
  parameter int RESP_CYCLES = tusseq_pkg::RESP_CYCLES
) (
  // Clock, reset and enable.
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  // Host command channel.
  input wire logic i_cmd_valid,
  input wire logic [29:0] i_cmd_word,
  output logic o_available,
  // Host status-report interrupt.
  output logic o_report_valid,
  output logic [29:0] o_report_word,
  input wire logic i_input_ack,
  // Tape drive pins, eight lines per drive, drive 1 in the lowest group.
  input wire logic [55:0] i_drive_lines,
  output logic [6:0] o_probe,
  output logic [6:0] o_cond_clear,
  output logic [6:0] o_query,
  output logic [6:0] o_instr_strobe,
  output logic [3:0] o_instr_lines,
  // Data transfer engine.
  output logic o_xfer_out_start,
  output logic o_xfer_in_start,
  input wire logic i_xfer_done,
  input wire logic i_timing_err,
  input wire logic i_parity_err
);

  // Short names for the drive geometry used all through this file.
  localparam int ND = tusseq_pkg::NUM_DRIVES;
  localparam int LPD = tusseq_pkg::LINES_PER_DRIVE;
  localparam int LBW = tusseq_pkg::LINE_BUS_W;

  // Whole sequencer state in one register.
  typedef struct packed {
    tusseq_pkg::tusseq_state_e st;
    logic [29:0] status;
    logic [29:0] cmd;
    logic [LBW-1:0] prev;
    logic [ND-1:0] got_probe;
    logic got_query;
  } tusseq_top_s;

  tusseq_top_s s;
  tusseq_top_s next_s;

  // Synchronised drive lines and their rising edges.
  logic [LBW-1:0] lines_sync;
  logic [LBW-1:0] lines_rise;
  // Addressed drive as a one-hot vector, drive 1 in bit 0.
  logic [ND-1:0] addr;
  // Ready bits of the status word reordered to drive order.
  logic [ND-1:0] rdy_vec;
  // Proceed decision of the decide state.
  logic go_ahead;

  // Start, stop and expiry of the response window travel together here.
  tusseq_tmr_if tmr ();

  if (RESP_CYCLES < 1) begin : g_window_check
    $error("tusseq_top needs a response window of at least one cycle.");
  end

  // Drive pulses come from another timing domain, so they pass two flops first.
  tusseq_sync #(
    .WIDTH(LBW)
  ) tusseq_sync_inst (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_clk_en(i_clk_en),
    .i_async(i_drive_lines),
    .o_sync(lines_sync)
  );

  // The window bounds the wait for silent drives.
  tusseq_timer #(
    .CYCLES(RESP_CYCLES)
  ) tusseq_timer_inst (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_clk_en(i_clk_en),
    .tmr(tmr.timer)
  );

  // A pulse is counted once, on its first synchronised cycle.
  assign lines_rise = lines_sync & ~s.prev;
  assign addr = s.cmd[tusseq_pkg::CMD_ADDR_LSB +: ND];

  // Reorder the ready bits, which run from bit 29 for drive 1 downward.
  always_comb begin
    for (int d = 0; d < ND; d++) begin
      rdy_vec[d] = s.status[tusseq_pkg::ST_READY_MSB - d];
    end
  end

  // Proceed only with a clean word and a ready answer from the target.
  assign go_ahead = (s.status[tusseq_pkg::ST_COND_SUM:tusseq_pkg::ST_FAULT_SUM] == 3'h0)
    && ((rdy_vec & addr) != 7'h0);

  // Pulses towards the drives and the timer are decoded from the state.
  always_comb begin
    o_probe = {ND{s.st == tusseq_pkg::ST_PROBE}};
    o_cond_clear = {ND{s.st == tusseq_pkg::ST_PROBE}};
    o_query = (s.st == tusseq_pkg::ST_PROBE) ? addr : 7'h0;
    o_instr_strobe = (s.st == tusseq_pkg::ST_DECIDE && go_ahead) ? addr : 7'h0;
    o_xfer_out_start = (s.st == tusseq_pkg::ST_DECIDE) && go_ahead && s.cmd[tusseq_pkg::CMD_XFER_OUT_BIT];
    o_xfer_in_start = (s.st == tusseq_pkg::ST_DECIDE) && go_ahead && s.cmd[tusseq_pkg::CMD_XFER_IN_BIT];
    tmr.start = (s.st == tusseq_pkg::ST_PROBE);
    tmr.stop = (s.st == tusseq_pkg::ST_WAIT) && (next_s.st != tusseq_pkg::ST_WAIT);
  end

  // Host side of the channel.
  assign o_available = (s.st == tusseq_pkg::ST_IDLE);
  assign o_report_valid = (s.st == tusseq_pkg::ST_REPORT);
  assign o_report_word = s.status;
  assign o_instr_lines = s.cmd[tusseq_pkg::CMD_INSTR_LSB +: tusseq_pkg::INSTR_W];

  // Next-state logic of the whole sequence.
  always_comb begin
    next_s = s;
    // Edge memory follows the lines every cycle, so no pulse is counted twice.
    next_s.prev = lines_sync;
    case (s.st)
      // Accept a command and start from a clean word.
      tusseq_pkg::ST_IDLE: begin
        if (i_cmd_valid) begin
          next_s.cmd = i_cmd_word;
          next_s.status = tusseq_pkg::STATUS_RESET;
          next_s.st = tusseq_pkg::ST_PROBE;
        end
      end
      // Probe, clear and query pulses go out in this single cycle.
      tusseq_pkg::ST_PROBE: begin
        next_s.got_probe = 7'h0;
        next_s.got_query = 1'b0;
        next_s.st = tusseq_pkg::ST_WAIT;
      end
      // Collect answers from every drive until all arrive or the window ends.
      tusseq_pkg::ST_WAIT: begin
        for (int d = 0; d < ND; d++) begin
          if (lines_rise[d * LPD + tusseq_pkg::LN_READY]) begin
            next_s.status[tusseq_pkg::ST_READY_MSB - d] = 1'b1;
            next_s.got_probe[d] = 1'b1;
          end
          if (lines_rise[d * LPD + tusseq_pkg::LN_NOT_READY]) begin
            next_s.got_probe[d] = 1'b1;
            if (addr[d]) begin
              next_s.status[tusseq_pkg::ST_NOT_READY] = 1'b1;
            end
          end
          // Only the addressed drive's query answers and fault count.
          if (addr[d]) begin
            if (lines_rise[d * LPD + tusseq_pkg::LN_FAULT]) begin
              next_s.status[tusseq_pkg::ST_DRIVE_FAULT] = 1'b1;
            end
            if (lines_rise[d * LPD + tusseq_pkg::LN_NO_COND]) begin
              next_s.got_query = 1'b1;
            end
            for (int k = 0; k < tusseq_pkg::NUM_COND; k++) begin
              if (lines_rise[d * LPD + tusseq_pkg::LN_COND_W + k]) begin
                next_s.got_query = 1'b1;
                if (!s.cmd[tusseq_pkg::CMD_LOCKOUT_BIT]) begin
                  next_s.status[tusseq_pkg::ST_COND_MSB - k] = 1'b1;
                end
              end
            end
          end
        end
        // Ending early saves the full window when every drive has spoken.
        if (tmr.expired || ((&next_s.got_probe) && next_s.got_query)) begin
          if ((next_s.got_probe & addr) == 7'h0) begin
            next_s.status[tusseq_pkg::ST_SILENT] = 1'b1;
          end
          next_s.st = tusseq_pkg::ST_DECIDE;
        end
      end
      // Instruct and start a transfer, or abandon and report at once.
      tusseq_pkg::ST_DECIDE: begin
        if (go_ahead && (s.cmd[tusseq_pkg::CMD_XFER_OUT_BIT] || s.cmd[tusseq_pkg::CMD_XFER_IN_BIT])) begin
          next_s.st = tusseq_pkg::ST_XFER;
        end else begin
          next_s.st = tusseq_pkg::ST_REPORT;
        end
      end
      // Transfer faults are only recorded while the transfer runs.
      tusseq_pkg::ST_XFER: begin
        if (i_timing_err) begin
          next_s.status[tusseq_pkg::ST_TIMING] = 1'b1;
        end
        if (i_parity_err) begin
          next_s.status[tusseq_pkg::ST_PARITY] = 1'b1;
        end
        if (i_xfer_done) begin
          next_s.st = tusseq_pkg::ST_REPORT;
        end
      end
      // Hold the interrupt and word until the host acknowledges.
      tusseq_pkg::ST_REPORT: begin
        if (i_input_ack) begin
          next_s.st = tusseq_pkg::ST_IDLE;
        end
      end
      // An unknown state falls back to idle rather than hanging the channel.
      default: begin
        next_s.st = tusseq_pkg::ST_IDLE;
      end
    endcase
    // Summaries follow their sources in the same cycle, so the word is never inconsistent.
    next_s.status[tusseq_pkg::ST_COND_SUM] =
      |next_s.status[tusseq_pkg::ST_COND_MSB:tusseq_pkg::ST_COND_LSB];
    next_s.status[tusseq_pkg::ST_FAULT_SUM] =
      |next_s.status[tusseq_pkg::ST_TIMING:tusseq_pkg::ST_DRIVE_FAULT];
  end

  // Commands outside the idle state are simply never looked at.
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      s <= '0;
    end else if (i_clk_en) begin
      s <= next_s;
    end
  end

  // The probe, clear and query pulses go out together.
  probe_all_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (s.st == tusseq_pkg::ST_PROBE) |-> (o_probe == 7'h7f && o_cond_clear == 7'h7f && o_query == addr))
    else $error("Probe cycle pulses are wrong.");

  // An instruction only reaches a drive whose ready bit is set.
  instr_ready_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (o_instr_strobe != 7'h0) |-> ((o_instr_strobe & rdy_vec) == o_instr_strobe))
    else $error("Instruction sent to a drive that was not ready.");

  // Fault summary matches its four sources in every report.
  fault_summary_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    o_report_valid |-> (o_report_word[0] == (|o_report_word[6:3])))
    else $error("Fault summary bit disagrees with bits 3 to 6.");

  // Condition summary matches the four condition bits.
  cond_summary_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    o_report_valid |-> (o_report_word[2] == (|o_report_word[14:11])))
    else $error("Condition summary bit disagrees with bits 11 to 14.");

  // Unused bits of the report stay zero.
  unused_zero_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    o_report_valid |-> (o_report_word[10:7] == 4'h0 && o_report_word[22:15] == 8'h0))
    else $error("Unused status bits are not zero.");

  // A flagged word aborts straight into the report.
  abort_report_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (s.st == tusseq_pkg::ST_DECIDE && i_clk_en && s.status[2:0] != 3'h0)
      |-> (o_instr_strobe == 7'h0 && !o_xfer_out_start && !o_xfer_in_start) ##1 o_report_valid)
    else $error("Flagged command was not abandoned with a report.");

  // A clean word with a ready target instructs that target.
  proceed_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (s.st == tusseq_pkg::ST_DECIDE && s.status[2:0] == 3'h0 && (rdy_vec & addr) != 7'h0)
      |-> (o_instr_strobe == addr))
    else $error("Clean command did not instruct the addressed drive.");

  // A command arriving while busy leaves the stored command untouched.
  busy_ignore_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (s.st != tusseq_pkg::ST_IDLE && i_cmd_valid && i_clk_en) |=> $stable(s.cmd))
    else $error("Command accepted while busy.");

  // Transfer fault bits move only in the transfer or when idle takes a command and clears the word.
  xfer_only_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_clk_en && s.st != tusseq_pkg::ST_XFER && s.st != tusseq_pkg::ST_IDLE) |=> $stable(s.status[6:5]))
    else $error("Transfer fault bit changed outside a transfer.");

  // The lockout keeps every condition bit clear.
  lockout_mask_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (s.st != tusseq_pkg::ST_IDLE && s.cmd[7]) |-> (s.status[14:11] == 4'h0))
    else $error("Condition bit set under lockout.");

  // The end of a transfer raises the report on the next cycle.
  done_report_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (s.st == tusseq_pkg::ST_XFER && i_xfer_done && i_clk_en) |=> o_report_valid)
    else $error("Report did not follow the end of the transfer.");

  // Every probe is a single-cycle pulse, so each drive sees one probe per command.
  probe_pulse_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (o_probe != 7'h0 && i_clk_en) |=> (o_probe == 7'h0))
    else $error("Probe pulse lasted more than one cycle.");

  // A ready bit can only come from a drive that answered the probe.
  ready_answer_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (s.st == tusseq_pkg::ST_DECIDE) |-> ((rdy_vec & ~s.got_probe) == 7'h0))
    else $error("Ready bit set for a drive that gave no answer.");

  // The silent flag is set exactly when the target never answered the probe.
  silent_flag_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (s.st == tusseq_pkg::ST_DECIDE) |-> (s.status[tusseq_pkg::ST_SILENT] == ((s.got_probe & addr) == 7'h0)))
    else $error("Silent drive flag disagrees with the probe answers.");

  // No instruction leaves while any of the three decision bits is set.
  strobe_clean_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (o_instr_strobe != 7'h0) |-> (s.status[2:0] == 3'h0))
    else $error("Instruction sent with a flagged status word.");

  // A transfer only starts together with the instruction to its drive.
  xfer_instr_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (o_xfer_out_start || o_xfer_in_start) |-> (o_instr_strobe == addr))
    else $error("Transfer started without instructing the addressed drive.");

  // The interrupt and its word stand until the host acknowledges.
  report_hold_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (o_report_valid && !(i_input_ack && i_clk_en)) |=> (o_report_valid && $stable(o_report_word)))
    else $error("Report dropped or changed before the acknowledge.");

endmodule

// file: verification/tusseq_drives.sv
// Behavioural model of seven tape drives answering probe and query pulses.
`timescale 1ns/100ps
module tusseq_drives (
  // Clock and pulses from the sequencer.
  input wire logic i_core_clk,
  input wire logic [6:0] i_probe,
  input wire logic [6:0] i_query,
  // Scenario setup: ready, silent and fault per drive, condition line and answer delay.
  input wire logic [6:0] i_ready,
  input wire logic [6:0] i_silent,
  input wire logic [6:0] i_fault,
  input wire logic [2:0] i_cond,
  input wire logic [3:0] i_delay,
  // Answer lines, eight per drive.
  output logic [55:0] o_lines
);
  // Counts down to the answer; two cycles of pulse at its end.
  logic [4:0] cnt = 5'h0;
  // Drives that received a condition query.
  logic [6:0] asked = 7'h0;
  logic act;
  // The model acts on the falling edge so that pin changes never race the sampling edge.
  always @(negedge i_core_clk) begin
    if (|i_probe) begin
      cnt <= 5'(i_delay) + 5'h2;
      asked <= i_query;
    end else if (cnt != 5'h0) begin
      cnt <= cnt - 5'h1;
    end
  end
  assign act = (cnt != 5'h0) && (cnt <= 5'h2);
  // Pulse lines idle low; a silent drive gives no answer at all, probe or query.
  always_comb begin
    o_lines = '0;
    for (int d = 0; d < 7; d++) begin
      if (act && !i_silent[d]) begin
        o_lines[d*8+0] = i_ready[d];
        o_lines[d*8+1] = !i_ready[d];
        if (asked[d]) begin
          o_lines[d*8+2] = i_fault[d];
          o_lines[d*8+3] = (i_cond == 3'h0);
          for (int k = 0; k < 4; k++) o_lines[d*8+4+k] = (i_cond == 3'(k+1));
        end
      end
    end
  end
endmodule

// file: verification/tusseq_top_bench.sv
// Self-checking bench for the tape status sequencer with a drive model.
`timescale 1ns/100ps
module tusseq_top_bench;
  // Short response window keeps silent-drive runs brief.
  localparam int RESP = 20;
  logic i_core_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_cmd_valid = 1'b0;
  logic [29:0] i_cmd_word = 30'h0;
  logic i_input_ack = 1'b0;
  logic i_xfer_done = 1'b0;
  logic i_timing_err = 1'b0;
  logic i_parity_err = 1'b0;
  logic o_available, o_report_valid, o_xfer_out_start, o_xfer_in_start;
  logic [29:0] o_report_word;
  logic [55:0] lines;
  logic [6:0] o_probe, o_cond_clear, o_query, o_instr_strobe;
  logic [3:0] o_instr_lines;
  // Drive model setup.
  logic [6:0] rdy = 7'h7f, sil = 7'h0, flt = 7'h0;
  logic [2:0] cnd = 3'h0;
  logic [3:0] dly = 4'h3;
  // Pulses seen during the current command.
  logic [6:0] cap_probe, cap_clear, cap_query, cap_strobe;
  logic [1:0] cap_xfer;
  // Clears the captures at the edge that takes a command; one driver for the captures.
  logic cap_clr = 1'b0;
  // Clock enable of the sequencer, low only in the freeze scenario.
  logic en = 1'b1;
  int fails = 0;
  int total_checks = 0;

  always #2.5 i_core_clk = ~i_core_clk;

  tusseq_top #(.RESP_CYCLES(RESP)) tusseq_top_inst (.i_core_clk(i_core_clk), .i_reset(i_reset),
    .i_clk_en(en), .i_cmd_valid(i_cmd_valid), .i_cmd_word(i_cmd_word), .o_available(o_available),
    .o_report_valid(o_report_valid), .o_report_word(o_report_word), .i_input_ack(i_input_ack),
    .i_drive_lines(lines), .o_probe(o_probe), .o_cond_clear(o_cond_clear), .o_query(o_query),
    .o_instr_strobe(o_instr_strobe), .o_instr_lines(o_instr_lines), .o_xfer_out_start(o_xfer_out_start),
    .o_xfer_in_start(o_xfer_in_start), .i_xfer_done(i_xfer_done), .i_timing_err(i_timing_err),
    .i_parity_err(i_parity_err));

  tusseq_drives tusseq_drives_inst (.i_core_clk(i_core_clk), .i_probe(o_probe), .i_query(o_query),
    .i_ready(rdy), .i_silent(sil), .i_fault(flt), .i_cond(cnd), .i_delay(dly), .o_lines(lines));

  // Pulses last one cycle, so they are collected at every rising edge.
  always @(posedge i_core_clk) begin
    if (cap_clr) begin
      {cap_probe, cap_clear, cap_query, cap_strobe, cap_xfer} <= '0;
    end else begin
      if (|o_probe) begin
        cap_probe <= o_probe;
        cap_clear <= o_cond_clear;
        cap_query <= o_query;
      end
      cap_strobe <= cap_strobe | o_instr_strobe;
      cap_xfer <= cap_xfer | {o_xfer_in_start, o_xfer_out_start};
    end
  end

  task automatic check(input logic [29:0] got, input logic [29:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One command: opt bit0 transfer out, bit1 transfer in, bit2 condition lockout.
  // Errors are held high through the control phase, where they must not count.
  task automatic run_cmd(input int a, input logic [3:0] ins, input logic [2:0] opt, input logic [1:0] errs);
    logic [29:0] w, e;
    logic go, sent;
    w = 30'h0;
    w[5:4] = opt[1:0];
    w[7] = opt[2];
    w[14:11] = ins;
    w[15+a] = 1'b1;
    e = 30'h0;
    for (int d = 0; d < 7; d++) e[29-d] = rdy[d] & !sil[d];
    e[1] = !sil[a] & !rdy[a];
    e[3] = flt[a] & !sil[a];
    e[4] = sil[a];
    if (!sil[a] && cnd != 3'h0 && !opt[2]) e[15-int'(cnd)] = 1'b1;
    e[2] = |e[14:11];
    e[0] = |e[6:3];
    go = (e[2:0] == 3'h0) && e[29-a];
    if (go && |opt[1:0]) e[6:5] = errs;
    e[0] = |e[6:3];
    sent = 1'b0;
    @(negedge i_core_clk);
    cap_clr = 1'b1;
    {i_timing_err, i_parity_err} = errs;
    i_cmd_word = w;
    i_cmd_valid = 1'b1;
    @(negedge i_core_clk);
    cap_clr = 1'b0;
    // A command offered while busy, to every drive at once, must leave no trace.
    i_cmd_word = 30'h003f_8000;
    repeat (3) @(negedge i_core_clk);
    i_cmd_valid = 1'b0;
    for (int n = 0; n < 200 && o_report_valid !== 1'b1; n++) begin
      i_xfer_done = (|cap_xfer) && !sent;
      sent = sent | i_xfer_done;
      @(negedge i_core_clk);
    end
    {i_xfer_done, i_timing_err, i_parity_err} = 3'h0;
    check(30'(o_report_valid), 30'h1);
    @(negedge i_core_clk);
    check(30'(o_report_valid), 30'h1);
    check(o_report_word, e);
    check(30'(cap_probe), 30'h7f);
    check(30'(cap_clear), 30'h7f);
    check(30'(cap_query), 30'(7'h1 << a));
    check(30'(cap_strobe), go ? 30'(7'h1 << a) : 30'h0);
    check(30'(cap_xfer), go ? 30'(opt[1:0]) : 30'h0);
    if (go) check(30'(o_instr_lines), 30'(ins));
    i_input_ack = 1'b1;
    @(negedge i_core_clk);
    i_input_ack = 1'b0;
    check(30'({o_available, o_report_valid}), 30'h2);
  endtask

  task automatic setup(input logic [6:0] r, s, f, input logic [2:0] c, input logic [3:0] dl);
    {rdy, sil, flt, cnd, dly} = {r, s, f, c, dl};
  endtask

  task automatic t_clean;
    setup(7'h7f, 7'h0, 7'h0, 3'h0, 4'h3);
    run_cmd(2, 4'ha, 3'b000, 2'b11);
    $display("test clean done");
  endtask

  task automatic t_cond;
    for (int c = 1; c <= 4; c++) begin
      setup(7'h7f, 7'h0, 7'h0, 3'(c), 4'h3);
      run_cmd(4, 4'h3, 3'b000, 2'b00);
      run_cmd(4, 4'h3, 3'b100, 2'b00);
    end
    $display("test condition lines done");
  endtask

  task automatic t_not_ready;
    setup(7'h55, 7'h0, 7'h0, 3'h0, 4'h9);
    run_cmd(1, 4'h5, 3'b001, 2'b00);
    $display("test not ready done");
  endtask

  task automatic t_silent;
    setup(7'h7f, 7'h21, 7'h0, 3'h0, 4'h3);
    run_cmd(5, 4'h6, 3'b000, 2'b00);
    $display("test silent drive done");
  endtask

  task automatic t_fault;
    setup(7'h7f, 7'h0, 7'h40, 3'h0, 4'h3);
    run_cmd(6, 4'h2, 3'b010, 2'b00);
    setup(7'h7f, 7'h0, 7'h0, 3'h0, 4'h3);
    run_cmd(6, 4'h2, 3'b010, 2'b00);
    $display("test drive fault done");
  endtask

  task automatic t_xfer;
    setup(7'h7f, 7'h0, 7'h0, 3'h0, 4'h3);
    run_cmd(0, 4'h1, 3'b001, 2'b10);
    run_cmd(3, 4'h8, 3'b010, 2'b01);
    run_cmd(3, 4'hf, 3'b010, 2'b00);
    $display("test transfers done");
  endtask

  // A low clock enable freezes the sequencer, so an offered command is not taken.
  task automatic t_freeze;
    setup(7'h7f, 7'h0, 7'h0, 3'h0, 4'h3);
    @(negedge i_core_clk);
    en = 1'b0;
    i_cmd_word = 30'h0000_8000;
    i_cmd_valid = 1'b1;
    repeat (3) @(negedge i_core_clk);
    check(30'({o_available, |o_probe}), 30'h2);
    i_cmd_valid = 1'b0;
    en = 1'b1;
    run_cmd(6, 4'h4, 3'b000, 2'b00);
    $display("test clock enable done");
  endtask

  // Reset in mid-run drops a standing report and returns the block to idle.
  task automatic t_reset;
    setup(7'h7f, 7'h0, 7'h01, 3'h0, 4'h3);
    @(negedge i_core_clk);
    i_cmd_word = 30'h0000_8000;
    i_cmd_valid = 1'b1;
    @(negedge i_core_clk);
    i_cmd_valid = 1'b0;
    repeat (12) @(negedge i_core_clk);
    check(30'(o_report_valid), 30'h1);
    i_reset = 1'b1;
    @(negedge i_core_clk);
    check(30'({o_available, o_report_valid, |o_probe}), 30'h4);
    check(o_report_word, 30'h0);
    i_reset = 1'b0;
    setup(7'h7f, 7'h0, 7'h0, 3'h0, 4'h3);
    run_cmd(0, 4'h9, 3'b000, 2'b00);
    $display("test mid-run reset done");
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Main sequence: reset for ten cycles, then every scenario in turn.
  initial begin
    repeat (10) @(negedge i_core_clk);
    i_reset = 1'b0;
    t_clean();
    t_cond();
    t_not_ready();
    t_silent();
    t_fault();
    t_xfer();
    t_freeze();
    t_reset();
    end_of_test();
  end

  // The scenarios need well under a thousand cycles; twenty thousand means a hang.
  initial begin
    #100000;
    fails++;
    end_of_test();
  end
endmodule
